// File: rtl/sdssr_pkg.sv
package sdssr_pkg;
   // ****************************************************
   // Register map and field layout
   // ****************************************************
   localparam logic [7:0] SDSSR_STATUS_OFFSET = 8'h04;
   localparam logic [7:0] SDSSR_STATUS_RESET = 8'h00;
   localparam int SDSSR_SHUTDOWN_BIT = 0;
   localparam int SDSSR_SHUTDOWN_IRQ_BIT = 1;
   localparam int SDSSR_BATTERY_BIT = 2;
   localparam int SDSSR_BATTERY_IRQ_BIT = 3;
   localparam int SDSSR_SLOT1_LSB = 4;
   localparam int SDSSR_SLOT2_LSB = 6;
   // Control register fields that feed the status codes
   localparam int SDSSR_SLOT1_REG_EN_BIT = 0;
   localparam int SDSSR_SLOT1_STATE_LSB = 2;
   localparam int SDSSR_SLOT2_REG_EN_BIT = 4;
   localparam int SDSSR_SLOT2_STATE_LSB = 6;
   // Slot status codes
   localparam logic [1:0] SDSSR_CODE_DOWN = 2'h0;
   localparam logic [1:0] SDSSR_CODE_ISOLATED = 2'h1;
   localparam logic [1:0] SDSSR_CODE_POWERED = 2'h2;
   localparam logic [1:0] SDSSR_CODE_ACTIVE = 2'h3;
endpackage : sdssr_pkg

// File: rtl/sdssr_slot_code.sv
`timescale 1ns/1ns
// ****************************************************
// Slot status encoder, registered output
// ****************************************************
module sdssr_slot_code
   import sdssr_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic reg_enable_in,
   input wire logic [1:0] iface_state_in,
   output logic [1:0] status_code_out
);
   logic [1:0] next_code;

   // Regulator off forces powered down; otherwise state 00 maps to powered, the rest straight through
   assign next_code = !reg_enable_in ? SDSSR_CODE_DOWN :
      (iface_state_in == SDSSR_CODE_DOWN) ? SDSSR_CODE_POWERED :
      iface_state_in;   // 01->01, 11->11, 10->10

   // Code register
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         status_code_out <= SDSSR_CODE_DOWN;
      else
         status_code_out <= next_code;
   end
endmodule : sdssr_slot_code

// File: rtl/sdssr_status.sv
`timescale 1ns/1ns
module sdssr_status
   import sdssr_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic shutdown_request_input_in,
   input wire logic shutdown_event_in,
   input wire logic battery_absent_in,
   input wire logic battery_removed_event_in,
   input wire logic [7:0] slot_control_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_read_in,
   input wire logic reg_write_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_hit_out
);
   // ****************************************************
   // Local signals
   // ****************************************************
   // Shutdown pin chain; bit 2 holds the oldest sample
   logic [2:0] sdn_sync;
   logic sdn_agree;
   logic sdn_level;
   logic next_sdn_level;
   // Interrupt flags and the battery level
   logic shutdown_irq;
   logic next_shutdown_irq;
   logic battery_irq;
   logic next_battery_irq;
   logic battery_absent;
   // Per-slot control fields and their encoded codes
   logic slot1_enable;
   logic slot2_enable;
   logic [1:0] slot1_state;
   logic [1:0] slot2_state;
   logic [1:0] slot1_code;
   logic [1:0] slot2_code;
   // Register access
   logic status_sel;
   logic status_read;
   logic [7:0] status_word;
   logic [7:0] next_rdata;

   // ****************************************************
   // Shutdown pin synchroniser
   // ****************************************************
   // Pin passes three flops; the first may go metastable, so only
   // the second and third are ever looked at
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         sdn_sync <= 3'h0;
      end
      else
      begin
         sdn_sync <= {sdn_sync[1:0], shutdown_request_input_in};
      end
   end

   // A change counts once the last two samples agree
   assign sdn_agree = (sdn_sync[2] == sdn_sync[1]);
   assign next_sdn_level = sdn_agree ? sdn_sync[2] : sdn_level;

   // Captured pin level shown on bit 0; lags the pin by three to four cycles
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         sdn_level <= 1'b0;
      end
      else
      begin
         sdn_level <= next_sdn_level;
      end
   end

   // ****************************************************
   // Register decode
   // ****************************************************
   // Only reads of the status offset are decoded; the address is
   // compared in full, so aliases of the offset never answer
   assign status_sel = (reg_addr_in == SDSSR_STATUS_OFFSET);
   assign status_read = status_sel && reg_read_in;
   // Writes are decoded nowhere: the status word has no writable bit, so a
   // stray write from the host can never disturb a pending flag

   // ****************************************************
   // Interrupt flags
   // ****************************************************
   // Set wins over the read clear: an event in the read cycle survives,
   // so the host sees it on its next read and no event is lost
   assign next_shutdown_irq = shutdown_event_in | (shutdown_irq & ~status_read);
   assign next_battery_irq = battery_removed_event_in | (battery_irq & ~status_read);

   // Shutdown request interrupt flag
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         shutdown_irq <= 1'b0;
      end
      else
      begin
         shutdown_irq <= next_shutdown_irq;
      end
   end

   // Battery removal interrupt flag
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         battery_irq <= 1'b0;
      end
      else
      begin
         battery_irq <= next_battery_irq;
      end
   end

   // ****************************************************
   // Battery level
   // ****************************************************
   // The input is already debounced on this clock, so one flop suffices;
   // it keeps the level aligned with the flags in the same status word
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         battery_absent <= 1'b0;
      end
      else
      begin
         battery_absent <= battery_absent_in;
      end
   end

   // ****************************************************
   // Slot status encoders
   // ****************************************************
   // Control fields of each slot, picked out by position; the control
   // copy is a level on this clock, so no synchroniser is needed
   assign slot1_enable = slot_control_in[SDSSR_SLOT1_REG_EN_BIT];
   assign slot1_state = slot_control_in[SDSSR_SLOT1_STATE_LSB +: 2];
   assign slot2_enable = slot_control_in[SDSSR_SLOT2_REG_EN_BIT];
   assign slot2_state = slot_control_in[SDSSR_SLOT2_STATE_LSB +: 2];

   // Slot 1 encoder; its code lags the control copy by one cycle
   sdssr_slot_code u_slot1 (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .reg_enable_in(slot1_enable),
      .iface_state_in(slot1_state),
      .status_code_out(slot1_code)
   );

   // Slot 2 encoder; same mapping as slot 1
   sdssr_slot_code u_slot2 (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .reg_enable_in(slot2_enable),
      .iface_state_in(slot2_state),
      .status_code_out(slot2_code)
   );

   // ****************************************************
   // Read data
   // ****************************************************
   // Status word assembly in bit order
   assign status_word = {slot2_code, slot1_code, battery_irq, battery_absent,
      shutdown_irq, sdn_level};
   // Idle cycles and unmapped addresses return zero, so a stale word
   // never lingers on the bus after its one-cycle answer
   assign next_rdata = status_read ? status_word : 8'h00;

   // Read data register; carries the word as it stood before the clear
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         reg_rdata_out <= SDSSR_STATUS_RESET;
      end
      else
      begin
         reg_rdata_out <= next_rdata;
      end
   end

   // Answer strobe, high for the one cycle in which the data stands
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         reg_hit_out <= 1'b0;
      end
      else
      begin
         reg_hit_out <= status_read;
      end
   end
endmodule : sdssr_status

// File: test/sdssr_host.sv
`timescale 1ns/1ns
module sdssr_host (
   input wire logic sys_clk_in,
   output logic [7:0] reg_addr_out,
   output logic reg_read_out,
   output logic reg_write_out,
   output logic [7:0] reg_wdata_out
);
   initial {reg_addr_out, reg_wdata_out, reg_read_out, reg_write_out} = 18'h00000;
   task xf(input logic w, input logic [7:0] a, d, input int n); // Strobe held n cycles
      @(negedge sys_clk_in);
      {reg_addr_out, reg_wdata_out, reg_read_out, reg_write_out} = {a, d, !w, w};
      repeat (n) @(negedge sys_clk_in);
      {reg_addr_out, reg_wdata_out, reg_read_out, reg_write_out} = {~a, ~d, 2'h0}; // Stale bus
   endtask : xf
endmodule : sdssr_host

// File: test/sdssr_status_properties.sv
`timescale 1ns/1ns
module sdssr_status_properties (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic shutdown_event_in,
   input wire logic battery_removed_event_in,
   input wire logic battery_absent_in,
   input wire logic [7:0] slot_control_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_read_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_hit_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   wire rd = reg_read_in && reg_addr_in == 8'h04; // Status read taken
   property p_idle; !rd |=> !reg_hit_out && reg_rdata_out == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("answer without read");
   property p_hit; rd |=> reg_hit_out; endproperty
   a_hit: assert property (p_hit) else $error("read unanswered");
   property p_rst; $past(rst_in) |-> reg_rdata_out == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("data after reset");
   property p_sset; shutdown_event_in ##1 rd |=> reg_rdata_out[1]; endproperty
   a_sset: assert property (p_sset) else $error("shutdown flag lost");
   property p_sclr; rd && !shutdown_event_in ##1 rd |=> !reg_rdata_out[1]; endproperty
   a_sclr: assert property (p_sclr) else $error("shutdown flag kept");
   property p_bset; battery_removed_event_in ##1 rd |=> reg_rdata_out[3]; endproperty
   a_bset: assert property (p_bset) else $error("battery flag lost");
   property p_bclr; rd && !battery_removed_event_in ##1 rd |=> !reg_rdata_out[3]; endproperty
   a_bclr: assert property (p_bclr) else $error("battery flag kept");
   property p_bat; rd |=> reg_rdata_out[2] == $past(battery_absent_in, 2); endproperty
   a_bat: assert property (p_bat) else $error("battery level wrong");
   property p_off1; rd && !$past(slot_control_in[0]) |=> reg_rdata_out[5:4] == 2'h0; endproperty
   a_off1: assert property (p_off1) else $error("slot 1 code not down");
   property p_off2; rd && !$past(slot_control_in[4]) |=> reg_rdata_out[7:6] == 2'h0; endproperty
   a_off2: assert property (p_off2) else $error("slot 2 code not down");
   property p_pow1;
      rd && $past(slot_control_in[0]) && $past(slot_control_in[3:2]) == 2'h0
         |=> reg_rdata_out[5:4] == 2'h2;
   endproperty
   a_pow1: assert property (p_pow1) else $error("slot 1 code not powered");
   property p_on1;
      rd && $past(slot_control_in[0]) && $past(slot_control_in[3:2]) != 2'h0
         |=> reg_rdata_out[5:4] == $past(slot_control_in[3:2], 2);
   endproperty
   a_on1: assert property (p_on1) else $error("slot 1 code not state");
endmodule : sdssr_status_properties
bind sdssr_status sdssr_status_properties u_props (.*);

// File: test/tb_sim_dual_slot_status_register.sv
`timescale 1ns/1ns
module tb_sim_dual_slot_status_register;
   logic sys_clk_in = 1'b0, rst_in, pin, sev, bab, bev, rd, wr, hit;
   logic [7:0] ctl, addr, wdata, rdata, q[$];
   logic [31:0] lf = 32'h000113c9;
   int num_errors = 0, n_compared = 0;
   sdssr_status DUT (.sys_clk_in, .rst_in, .shutdown_request_input_in(pin),
      .shutdown_event_in(sev), .battery_absent_in(bab), .battery_removed_event_in(bev),
      .slot_control_in(ctl), .reg_addr_in(addr), .reg_read_in(rd), .reg_write_in(wr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit));
   sdssr_host u_host (.sys_clk_in, .reg_addr_out(addr), .reg_read_out(rd),
      .reg_write_out(wr), .reg_wdata_out(wdata));
   initial forever #25 sys_clk_in = ~sys_clk_in;
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task chk(input string name, input logic [7:0] seen, exp);
      n_compared++;
      num_errors += int'(seen !== exp);
      if (seen !== exp) $display("mismatch %s exp %h seen %h", name, exp, seen);
   endtask : chk
   task finish_test;
      $display("checks %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   always @(negedge sys_clk_in) // Each answer against the oldest note
      if (hit === 1'b1) chk("status", rdata, q.size() > 0 ? q.pop_front() : 8'hxx);
   initial
   begin
      {rst_in, pin, sev, bab, bev, ctl} = 13'h1a00;
      repeat (3) @(negedge sys_clk_in);
      rst_in = 1'b0;
      chk("rdata_reset", rdata, 8'h00);
      chk("hit_reset", {7'h00, hit}, 8'h00);
      for (int i = 0; i < 8; i++) // Both slots meet every regulator and state pair
      begin
         lf = lfsr_next(lf);
         ctl = {~i[1:0], lf[0], ~i[2], i[1:0], lf[1], i[2]};
         u_host.xf(1'b1, 8'h04, lf[15:8], 1);
         u_host.xf(1'b0, 8'h05, 8'h00, 1);
         q.push_back({2'(16'he600 >> 14 - 2 * i), 2'(16'he600 >> 2 * i), 4'h5});
         u_host.xf(1'b0, 8'h04, 8'h00, 1);
      end
      $display("slot code test done");
      {pin, bab} = 2'h0; // Low levels settle through the pin chain first
      repeat (5) @(negedge sys_clk_in);
      {sev, bev} = 2'h3; // Events land one cycle ahead of two reads back to back
      {sev, bev} <= #50 2'h0;
      q.push_back(8'h3a);
      q.push_back(8'h30);
      u_host.xf(1'b0, 8'h04, 8'h00, 2);
      repeat (2) @(negedge sys_clk_in);
      $display("event flag test done");
      chk("notes_left", 8'(q.size()), 8'h00);
      finish_test();
   end
endmodule : tb_sim_dual_slot_status_register
